// *** core/track_gate_pkg.sv ***
// Constants, types and timing figures for the track gate sequencer
package track_gate_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_SECTOR = 5'h04;
	localparam logic [4:0] ADDR_SYNC = 5'h08;
	localparam logic [4:0] ADDR_GAP = 5'h0C;
	localparam logic [4:0] ADDR_STATUS = 5'h10;
	localparam int CTRL_START_BIT = 7;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ----------------------------------------
	// Timing in bit times
	// ----------------------------------------
	localparam int BITS_PER_BYTE = 8;
	localparam int LATENCY_BITS = 8;
	localparam int SYNC_LAT = 3;
	localparam int WG_ON_BITS = 17;
	localparam int WG_OFF_BITS = 28;
	localparam int WG_OFF_PULSED_BITS = 20;
	localparam int WG_LOW_BITS = 2;
	localparam int WG_OFF_NRZ_BITS = 8;
	localparam int RG_OFF_BITS = 9;
	localparam int RG_ON_RUN_BITS = 19;
	localparam int RG_ON_DATA_BITS = 35;
	localparam int FMT_DATA_PRE_BYTES = 11;
	localparam int WR_PRE_ZERO_BYTES = 12;
	localparam int WR_PRE_ADD_BYTES = 13;
	localparam int FMT_GAP_ADD_BYTES = 5;
	localparam logic [7:0] PRE_BYTE = 8'h00;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		OP_READ = 2'b00,
		OP_WRITE = 2'b01,
		OP_FORMAT = 2'b10
	} op_t;

	typedef struct packed {
		logic pulsed;
		logic unenc;
		logic hard;
		op_t op;
	} mode_t;

	typedef struct packed {
		mode_t mode;
		logic [7:0] sector;
		logic [7:0] sync_len;
		logic [7:0] gap;
	} cfg_t;

endpackage : track_gate_pkg

// *** core/gate_timer.sv ***
// Down counter that pulses once a loaded bit-time delay elapses
`timescale 1ns/10ps
module gate_timer #(
	parameter int W = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic done
);
	logic [W-1:0] cnt_q;
	logic run_q;

	if (W < 6) begin : g_w_check
		$error("gate_timer width too small");
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// A load of zero still takes one cycle, never less
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (load) begin
			cnt_q <= value;
			run_q <= 1'b1;
		end else if (run_q) begin
			if (cnt_q <= W'(1)) begin
				run_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q - W'(1);
			end
		end
	end

	assign done = run_q && !load && (cnt_q <= W'(1));

endmodule : gate_timer

// *** core/track_gate_sequencer.sv ***
// Read and write gate sequencer for one sector of a disk track
`timescale 1ns/10ps
module track_gate_sequencer #(
	parameter int TW = 12
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic clk_link,
	input wire logic index_pulse,
	input wire logic run_or_sector_input,
	input wire logic unencoded_read_in,
	input wire logic read_mark_in,
	input wire logic write_data_in,
	input wire logic write_data_end,
	output logic read_gate_out,
	output logic write_gate_out,
	output logic unencoded_write_out,
	output logic encoded_write_out,
	output logic read_bit_out
);
	import track_gate_pkg::*;

	// Elaboration check: gap and sector delays need twelve bits
	if (TW < 12) begin : g_tw_check
		$error("timer width cannot hold gap delays");
	end

	// ----------------------------------------
	// System side registers
	// ----------------------------------------
	cfg_t cfg_q;
	logic busy_q;
	logic done_q;
	logic start_tgl_q;
	logic [2:0] done_sync_q;
	logic done_tgl_q;
	logic done_evt;

	assign done_evt = done_sync_q[2] ^ done_sync_q[1];

	// Settings are frozen while busy so the link side
	// can sample them without a word crossing
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfg_q <= '0;
		end else if (wr && !busy_q) begin
			case (addr)
				ADDR_CTRL: begin
					cfg_q.mode <= mode_t'(wdata[4:0]);
				end
				ADDR_SECTOR: begin
					cfg_q.sector <= wdata;
				end
				ADDR_SYNC: begin
					cfg_q.sync_len <= wdata;
				end
				ADDR_GAP: begin
					cfg_q.gap <= wdata;
				end
				default: begin
					cfg_q <= cfg_q;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_q <= 1'b0;
			start_tgl_q <= 1'b0;
		end else if (!busy_q && wr && addr == ADDR_CTRL && wdata[CTRL_START_BIT]) begin
			busy_q <= 1'b1;
			start_tgl_q <= ~start_tgl_q;
		end else if (done_evt) begin
			busy_q <= 1'b0;
		end
	end

	// Completion flag: a new completion beats a read clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			done_q <= 1'b0;
		end else if (done_evt) begin
			done_q <= 1'b1;
		end else if (rd && addr == ADDR_STATUS) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			done_sync_q <= '0;
		end else begin
			done_sync_q <= {done_sync_q[1:0], done_tgl_q};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata <= RESET_BYTE;
		end else if (rd) begin
			case (addr)
				ADDR_CTRL: begin
					rdata <= {3'h0, cfg_q.mode};
				end
				ADDR_SECTOR: begin
					rdata <= cfg_q.sector;
				end
				ADDR_SYNC: begin
					rdata <= cfg_q.sync_len;
				end
				ADDR_GAP: begin
					rdata <= cfg_q.gap;
				end
				ADDR_STATUS: begin
					rdata <= {6'h00, done_q, busy_q};
				end
				default: begin
					rdata <= RESET_BYTE;
				end
			endcase
		end else begin
			rdata <= RESET_BYTE;
		end
	end

	// ----------------------------------------
	// Link side crossings
	// ----------------------------------------
	logic [1:0] lrst_q;
	logic lrst;
	logic [2:0] start_sync_q;
	logic [2:0] idx_sync_q;
	logic [2:0] run_sync_q;
	logic [2:0] mark_sync_q;
	logic [1:0] rdat_sync_q;
	logic start_evt;
	logic idx_rise;
	logic run_rise;
	logic mark_rise;

	assign lrst = lrst_q[1];

	always_ff @(posedge clk_link) begin
		lrst_q <= {lrst_q[0], rst};
	end

	// Stage 1 feeds stage 2 only; edges use stages 2 and 3
	always_ff @(posedge clk_link) begin
		if (lrst) begin
			start_sync_q <= '0;
			idx_sync_q <= '0;
			run_sync_q <= '0;
			mark_sync_q <= '0;
			rdat_sync_q <= '0;
		end else begin
			start_sync_q <= {start_sync_q[1:0], start_tgl_q};
			idx_sync_q <= {idx_sync_q[1:0], index_pulse};
			run_sync_q <= {run_sync_q[1:0], run_or_sector_input};
			mark_sync_q <= {mark_sync_q[1:0], read_mark_in};
			rdat_sync_q <= {rdat_sync_q[0], unencoded_read_in};
		end
	end

	assign start_evt = start_sync_q[2] ^ start_sync_q[1];
	assign idx_rise = idx_sync_q[1] && !idx_sync_q[2];
	assign run_rise = run_sync_q[1] && !run_sync_q[2];
	assign mark_rise = mark_sync_q[1] && !mark_sync_q[2];

	// ----------------------------------------
	// Gate timers
	// ----------------------------------------
	logic tm_load;
	logic [TW-1:0] tm_val;
	logic tm_done;
	logic off_load;
	logic off_done;

	gate_timer #(.W(TW)) u_tm (
		.clk(clk_link),
		.rst(lrst),
		.load(tm_load),
		.value(tm_val),
		.done(tm_done)
	);

	// Read gate release runs beside the next gate-on delay
	gate_timer #(.W(TW)) u_off (
		.clk(clk_link),
		.rst(lrst),
		.load(off_load),
		.value(TW'(RG_OFF_BITS - SYNC_LAT)),
		.done(off_done)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_WAIT_EVT = 4'b0001,
		S_RG_DELAY = 4'b0010,
		S_RG_ID = 4'b0011,
		S_ID_GAP = 4'b0100,
		S_RD_DATA = 4'b0101,
		S_RD_TAIL = 4'b0110,
		S_FMT_DELAY = 4'b0111,
		S_ID_PRE = 4'b1000,
		S_ID_FIELD = 4'b1001,
		S_WG_LOW = 4'b1010,
		S_DATA_PRE = 4'b1011,
		S_DATA = 4'b1100,
		S_WG_TAIL = 4'b1101,
		S_DONE = 4'b1110
	} state_t;

	state_t st_q;
	cfg_t lcfg_q;
	logic [8:0] bytes_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q;
	logic byte_end;
	logic evt;
	logic [8:0] wr_pre;
	logic [TW-1:0] gap_bits;
	logic [TW-1:0] fmt_bits;

	assign byte_end = bit_q == 3'(BITS_PER_BYTE - 1);
	assign evt = idx_rise || run_rise;
	assign wr_pre = (lcfg_q.sync_len == 8'h00) ? 9'(WR_PRE_ZERO_BYTES) :
		9'(lcfg_q.sync_len) + 9'(WR_PRE_ADD_BYTES);
	assign gap_bits = TW'({lcfg_q.gap, 3'h0}) + TW'(LATENCY_BITS - SYNC_LAT);
	assign fmt_bits = lcfg_q.mode.pulsed ?
		TW'({9'(lcfg_q.sector) + 9'(FMT_GAP_ADD_BYTES), 3'h0}) + TW'(LATENCY_BITS - SYNC_LAT) :
		TW'(LATENCY_BITS - SYNC_LAT);

	always_comb begin
		tm_load = 1'b0;
		tm_val = '0;
		off_load = 1'b0;
		case (st_q)
			S_WAIT_EVT: begin
				tm_load = evt;
				if (lcfg_q.mode.op == OP_FORMAT) begin
					tm_val = fmt_bits;
				end else if (lcfg_q.mode.hard) begin
					tm_val = gap_bits;
				end else begin
					tm_val = TW'(RG_ON_RUN_BITS - SYNC_LAT);
				end
			end
			S_RG_ID: begin
				tm_load = mark_rise;
				off_load = mark_rise;
				if (lcfg_q.mode.op == OP_WRITE) begin
					tm_val = TW'(WG_ON_BITS - SYNC_LAT);
				end else begin
					tm_val = TW'(RG_ON_DATA_BITS - SYNC_LAT);
				end
			end
			S_RD_DATA: begin
				off_load = mark_rise;
			end
			S_ID_FIELD: begin
				tm_load = byte_end && lcfg_q.mode.hard && lcfg_q.mode.unenc;
				tm_val = TW'(WG_LOW_BITS);
			end
			S_DATA: begin
				tm_load = write_data_end;
				if (lcfg_q.mode.hard && lcfg_q.mode.unenc) begin
					tm_val = TW'(WG_OFF_NRZ_BITS);
				end else if (lcfg_q.mode.pulsed) begin
					tm_val = TW'(WG_OFF_PULSED_BITS);
				end else begin
					tm_val = TW'(WG_OFF_BITS);
				end
			end
			default: begin
				tm_load = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_link) begin
		if (lrst) begin
			st_q <= S_IDLE;
			lcfg_q <= '0;
			done_tgl_q <= 1'b0;
		end else begin
			case (st_q)
				S_IDLE: begin
					if (start_evt) begin
						lcfg_q <= cfg_q;
						st_q <= S_WAIT_EVT;
					end
				end
				S_WAIT_EVT: begin
					if (evt) begin
						st_q <= (lcfg_q.mode.op == OP_FORMAT) ? S_FMT_DELAY : S_RG_DELAY;
					end
				end
				S_RG_DELAY: begin
					if (tm_done) begin
						st_q <= S_RG_ID;
					end
				end
				S_RG_ID: begin
					if (mark_rise) begin
						st_q <= S_ID_GAP;
					end
				end
				S_ID_GAP: begin
					if (tm_done) begin
						st_q <= (lcfg_q.mode.op == OP_WRITE) ? S_DATA_PRE : S_RD_DATA;
					end
				end
				S_RD_DATA: begin
					if (mark_rise) begin
						st_q <= S_RD_TAIL;
					end
				end
				S_RD_TAIL: begin
					if (off_done) begin
						st_q <= S_DONE;
					end
				end
				S_FMT_DELAY: begin
					if (tm_done) begin
						st_q <= (lcfg_q.sync_len == 8'h00) ? S_ID_FIELD : S_ID_PRE;
					end
				end
				S_ID_PRE: begin
					if (byte_end && bytes_q == 9'h001) begin
						st_q <= S_ID_FIELD;
					end
				end
				S_ID_FIELD: begin
					if (byte_end) begin
						st_q <= tm_load ? S_WG_LOW : S_DATA_PRE;
					end
				end
				S_WG_LOW: begin
					if (tm_done) begin
						st_q <= S_DATA_PRE;
					end
				end
				S_DATA_PRE: begin
					if (byte_end && bytes_q == 9'h001) begin
						st_q <= S_DATA;
					end
				end
				S_DATA: begin
					if (write_data_end) begin
						st_q <= S_WG_TAIL;
					end
				end
				S_WG_TAIL: begin
					if (tm_done) begin
						st_q <= S_DONE;
					end
				end
				S_DONE: begin
					done_tgl_q <= ~done_tgl_q;
					st_q <= S_IDLE;
				end
				default: begin
					st_q <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Byte framing of written fields
	// ----------------------------------------
	always_ff @(posedge clk_link) begin
		if (lrst) begin
			bit_q <= '0;
			bytes_q <= '0;
			sh_q <= PRE_BYTE;
		end else if (st_q == S_FMT_DELAY && tm_done) begin
			bit_q <= '0;
			bytes_q <= 9'(lcfg_q.sync_len);
			sh_q <= (lcfg_q.sync_len == 8'h00) ? lcfg_q.sector : PRE_BYTE;
		end else if ((st_q == S_ID_GAP && tm_done) || (st_q == S_WG_LOW && tm_done)) begin
			bit_q <= '0;
			bytes_q <= (lcfg_q.mode.op == OP_WRITE) ? wr_pre : 9'(FMT_DATA_PRE_BYTES);
			sh_q <= PRE_BYTE;
		end else if (st_q == S_ID_PRE || st_q == S_ID_FIELD || st_q == S_DATA_PRE) begin
			bit_q <= bit_q + 3'h1;
			sh_q <= {sh_q[6:0], 1'b0};
			if (byte_end) begin
				bytes_q <= bytes_q - 9'h001;
				if (st_q == S_ID_PRE && bytes_q == 9'h001) begin
					sh_q <= lcfg_q.sector;
				end else if (st_q == S_ID_FIELD && !tm_load) begin
					bytes_q <= 9'(FMT_DATA_PRE_BYTES);
					sh_q <= PRE_BYTE;
				end else begin
					sh_q <= PRE_BYTE;
				end
			end
		end
	end

	// ----------------------------------------
	// Gates and serial outputs
	// ----------------------------------------
	always_ff @(posedge clk_link) begin
		if (lrst) begin
			read_gate_out <= 1'b0;
		end else if (st_q == S_RG_DELAY && tm_done) begin
			read_gate_out <= 1'b1;
		end else if (st_q == S_ID_GAP && tm_done && lcfg_q.mode.op == OP_READ) begin
			read_gate_out <= 1'b1;
		end else if (off_done) begin
			read_gate_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_link) begin
		if (lrst) begin
			write_gate_out <= 1'b0;
		end else if ((st_q == S_FMT_DELAY || st_q == S_WG_LOW) && tm_done) begin
			write_gate_out <= 1'b1;
		end else if (st_q == S_ID_GAP && tm_done && lcfg_q.mode.op == OP_WRITE) begin
			write_gate_out <= 1'b1;
		end else if (st_q == S_ID_FIELD && tm_load) begin
			write_gate_out <= 1'b0;
		end else if (st_q == S_WG_TAIL && tm_done) begin
			write_gate_out <= 1'b0;
		end
	end

	// Encoded stream is a transition code of the unencoded one
	always_ff @(posedge clk_link) begin
		if (lrst) begin
			unencoded_write_out <= 1'b0;
			encoded_write_out <= 1'b0;
			read_bit_out <= 1'b0;
		end else begin
			unencoded_write_out <= (st_q == S_DATA) ? write_data_in : sh_q[7];
			if ((st_q == S_DATA) ? write_data_in : sh_q[7]) begin
				encoded_write_out <= ~encoded_write_out;
			end
			read_bit_out <= read_gate_out & rdat_sync_q[1];
		end
	end

endmodule : track_gate_sequencer

// *** test/track_gate_sequencer_assertions.sv ***
// Concurrent checks on the link-side gate timing of the sequencer
`timescale 1ns/10ps
module track_gate_sequencer_assertions
	import track_gate_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic clk_link,
	input wire logic index_pulse,
	input wire logic run_or_sector_input,
	input wire logic read_mark_in,
	input wire logic write_data_end,
	input wire logic read_gate_out,
	input wire logic write_gate_out
);
	mode_t mode_q;
	logic [7:0] sector_q;
	logic [7:0] gap_q;
	logic [12:0] cnt_q;
	logic [12:0] fmt_base;
	logic [3:0] flag_q;

	// ----
	// Shadow of the setup
	// ----
	// Captured on the system clock; writes are taken even while an operation runs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_q <= mode_t'(5'h00);
			sector_q <= 8'h00;
			gap_q <= 8'h00;
		end else if (wr) begin
			if (addr == ADDR_CTRL && wdata[CTRL_START_BIT]) mode_q <= mode_t'(wdata[4:0]);
			if (addr == ADDR_SECTOR) sector_q <= wdata;
			if (addr == ADDR_GAP) gap_q <= wdata;
		end
	end

	// Bit times since the last index or sector event, plus first-edge flags and a read mark parity flag
	always_ff @(posedge clk_link) begin
		if (rst) begin
			cnt_q <= 13'h1FFF;
			flag_q <= 4'hF;
		end else if ($rose(index_pulse) || $rose(run_or_sector_input)) begin
			cnt_q <= 13'h0001;
			flag_q <= 4'h0;
		end else begin
			if (cnt_q != 13'h1FFF) cnt_q <= cnt_q + 13'h0001;
			flag_q[0] <= flag_q[0] | $rose(read_gate_out);
			flag_q[1] <= flag_q[1] | $rose(write_gate_out);
			flag_q[2] <= flag_q[2] ^ ($rose(read_mark_in) && read_gate_out);
			flag_q[3] <= flag_q[3] | write_data_end;
		end
	end
	assign fmt_base = mode_q.pulsed ? {2'b00, sector_q, 3'b000} + 13'h0028 : 13'h0000;

	// ----
	// Gate timing
	// ----
	default clocking cb @(posedge clk_link); endclocking
	default disable iff (rst);
	sequence s_low_two;
		##1 !write_gate_out ##1 write_gate_out;
	endsequence
	a_rg_run_on: assert property (mode_q.op != OP_FORMAT && !mode_q.hard && $rose(run_or_sector_input)
		|-> ##[18:20] $rose(read_gate_out)) else $error("read gate late after data run");
	a_rg_hard_on: assert property (mode_q.op != OP_FORMAT && mode_q.hard && !flag_q[0] && $rose(read_gate_out)
		|-> cnt_q >= {2'b00, gap_q, 3'b000} + 13'h0004 && cnt_q <= {2'b00, gap_q, 3'b000} + 13'h000C)
		else $error("hard sector read gate off its gap");
	a_fmt_wg_on: assert property (mode_q.op == OP_FORMAT && !flag_q[1] && $rose(write_gate_out)
		|-> cnt_q >= fmt_base + 13'h0004 && cnt_q <= fmt_base + 13'h000C) else $error("format write gate mistimed");
	a_rg_off_mark: assert property ($rose(read_mark_in) && read_gate_out
		|-> ##[8:10] $fell(read_gate_out)) else $error("read gate release mistimed");
	a_rg_data_on: assert property (mode_q.op == OP_READ && !flag_q[2] && $rose(read_mark_in) && read_gate_out
		|-> ##[35:36] $rose(read_gate_out)) else $error("data read gate mistimed");
	a_wg_on_mark: assert property (mode_q.op == OP_WRITE && $rose(read_mark_in) && read_gate_out
		|-> ##[16:18] $rose(write_gate_out)) else $error("write gate on mistimed");
	a_wg_off_tail: assert property (write_data_end && write_gate_out && !mode_q.pulsed
		&& !(mode_q.hard && mode_q.unenc) |-> ##[27:29] $fell(write_gate_out)) else $error("write gate off mistimed");
	a_wg_off_pulse: assert property (write_data_end && write_gate_out && mode_q.pulsed
		|-> ##[19:21] $fell(write_gate_out)) else $error("pulsed write gate off mistimed");
	a_wg_off_nrz: assert property (write_data_end && write_gate_out && mode_q.hard && mode_q.unenc
		&& !mode_q.pulsed |-> ##[7:9] $fell(write_gate_out)) else $error("unencoded write gate off mistimed");
	a_wg_gap_nrz: assert property (mode_q.op == OP_FORMAT && mode_q.hard && mode_q.unenc && !flag_q[3]
		&& $fell(write_gate_out) |-> s_low_two) else $error("write gate gap not two bits");
endmodule : track_gate_sequencer_assertions

// *** test/far_side_model.sv ***
// Behavioural drive and data separator on the far side of the link
`timescale 1ns/10ps
module far_side_model (
	input wire logic clk_link,
	output logic index_pulse,
	output logic run_or_sector_input,
	output logic unencoded_read_in,
	output logic read_mark_in,
	output logic write_data_in,
	output logic write_data_end
);
	logic [3:0] line_q = 4'h0;
	assign {write_data_end, read_mark_in, run_or_sector_input, index_pulse} = line_q;
	// Data field is all ones, so the first one ends the preamble
	assign write_data_in = 1'b1;
	// Read data toggles every bit time, so a sample stale by an odd number of bit times never passes
	initial unencoded_read_in = 1'b0;
	always @(posedge clk_link) begin
		unencoded_read_in <= ~unencoded_read_in;
	end
	// Board steers sector pulse or data run to the shared pin
	task automatic pulse(input int which, input int wait_bits, input int len);
		repeat (wait_bits + 1) @(posedge clk_link);
		line_q[which] <= 1'b1;
		repeat (len) @(posedge clk_link);
		line_q[which] <= 1'b0;
	endtask : pulse
endmodule : far_side_model

// *** test/tb_track_gate_sequencer.sv ***
// Self-checking bench for the track gate sequencer
`timescale 1ns/10ps
module tb_track_gate_sequencer;
	import track_gate_pkg::*;
	logic clk_sys, clk_link, rst, wr, rd;
	logic [4:0] addr;
	logic [7:0] wdata, rdata, d, n, s, c;
	logic index_pulse, run_or_sector_input, unencoded_read_in, read_mark_in, write_data_in, write_data_end;
	logic read_gate_out, write_gate_out, unencoded_write_out, encoded_write_out, read_bit_out;
	logic enc_p = 1'b0;
	logic rg_p = 1'b0;
	logic uri_p = 1'b0;
	int miscompares = 0;
	int num_checks = 0;
	int cyc = 0;
	int p;
	logic [31:0] seed = 32'h0000001A;
	logic bits_q[$];

	track_gate_sequencer #(.TW(12)) u_track_gate_sequencer (
		.clk_sys, .rst, .addr, .wdata, .wr, .rd, .rdata, .clk_link, .index_pulse, .run_or_sector_input,
		.unencoded_read_in, .read_mark_in, .write_data_in, .write_data_end, .read_gate_out,
		.write_gate_out, .unencoded_write_out, .encoded_write_out, .read_bit_out
	);
	far_side_model u_far_side_model (.clk_link, .index_pulse, .run_or_sector_input, .unencoded_read_in,
		.read_mark_in, .write_data_in, .write_data_end);

	// ----
	// Clocks, capture and helpers
	// ----
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Offset start keeps the link clock out of phase with the system clock
	initial begin
		clk_link = 1'b0;
		#7;
		forever #40 clk_link = ~clk_link;
	end
	always @(posedge clk_link) begin
		if (write_gate_out === 1'b1) bits_q.push_back(unencoded_write_out);
		// Transition code matches the unencoded bit of the same bit time; gated read data is checked against the gate and read data of one bit time earlier
		if (rst === 1'b0 && ((encoded_write_out ^ enc_p) !== unencoded_write_out || (rg_p & uri_p) !== read_bit_out)) begin
			miscompares++;
			$display("[ERR] %0t serial output mismatch", $time);
		end
		enc_p = encoded_write_out;
		rg_p = read_gate_out;
		uri_p = unencoded_read_in;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 100000) begin
			miscompares++;
			end_sim();
		end
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic int first_one(input int from);
		for (int i = from; i < bits_q.size(); i++) if (bits_q[i] === 1'b1) return i;
		return -1;
	endfunction : first_one
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim
	task automatic reg_wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		@(posedge clk_sys);
		v = rdata;
	endtask : reg_rd
	task automatic start(input logic [7:0] cv);
		bits_q.delete();
		reg_wr(ADDR_CTRL, cv);
		repeat (6) @(posedge clk_link);
	endtask : start
	task automatic wait_gate(input bit wg, input logic v);
		int i;
		for (i = 0; i < 3000 && (wg ? write_gate_out : read_gate_out) !== v; i++) @(posedge clk_link);
		chk(16'(i < 3000), 16'h0001);
	endtask : wait_gate
	task automatic finish_op();
		int i;
		d = 8'h00;
		for (i = 0; i < 200 && d[STAT_DONE_BIT] !== 1'b1; i++) reg_rd(ADDR_STATUS, d);
		chk(16'(d[STAT_DONE_BIT]), 16'h0001);
	endtask : finish_op

	// ----
	// Scenarios
	// ----
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 5'h00;
		wdata = 8'h00;
		repeat (20) @(posedge clk_sys);
		repeat (4) @(posedge clk_link);
		@(posedge clk_sys);
		rst <= 1'b0;
		n = 8'(rnd());
		reg_wr(ADDR_SECTOR, n);
		reg_rd(ADDR_SECTOR, d);
		chk(16'(d), 16'(n));
		reg_rd(5'h14, d);
		chk(16'(d), 16'h0000);
		// Soft then hard read; setup writes while busy must be dropped
		for (int k = 0; k < 2; k++) begin
			reg_wr(ADDR_GAP, 8'(rnd() % 4));
			start(k ? 8'h84 : 8'h80);
			reg_rd(ADDR_STATUS, d);
			chk(16'(d[STAT_BUSY_BIT]), 16'h0001);
			reg_wr(ADDR_SECTOR, ~n);
			u_far_side_model.pulse(1, 0, 2);
			wait_gate(0, 1);
			u_far_side_model.pulse(2, 5, 2);
			wait_gate(0, 0);
			wait_gate(0, 1);
			u_far_side_model.pulse(2, 20, 2);
			wait_gate(0, 0);
			finish_op();
			reg_rd(ADDR_SECTOR, d);
			chk(16'(d), 16'(n));
		end
		// Write with an empty and a programmed sync length
		for (int k = 0; k < 2; k++) begin
			s = k ? 8'(rnd() % 3 + 1) : 8'h00;
			reg_wr(ADDR_SYNC, s);
			start(8'h81);
			u_far_side_model.pulse(1, 0, 2);
			wait_gate(0, 1);
			u_far_side_model.pulse(2, 5, 2);
			wait_gate(1, 1);
			repeat (s * 8 + 128) @(posedge clk_link);
			u_far_side_model.pulse(3, 0, 1);
			wait_gate(1, 0);
			finish_op();
			p = first_one(0) - (k ? s * 8 + 104 : 96);
			chk(16'(p >= -8 && p <= 8), 16'h0001);
		end
		// Format: soft, hard pulsed, hard unencoded
		for (int k = 0; k < 3; k++) begin
			c = k == 0 ? 8'h82 : (k == 1 ? 8'h96 : 8'h8E);
			n = k ? 8'(rnd() % 4) : 8'h80 | 8'(rnd());
			s = 8'(rnd() % 3 + 1);
			reg_wr(ADDR_SECTOR, n);
			reg_wr(ADDR_SYNC, s);
			start(c);
			u_far_side_model.pulse(k ? 1 : 0, 0, 2);
			wait_gate(1, 1);
			repeat (s * 8 + 136) @(posedge clk_link);
			u_far_side_model.pulse(3, 0, 1);
			wait_gate(1, 0);
			finish_op();
			if (k == 0) begin
				p = first_one(0);
				chk(16'(p >= s * 8 && p <= s * 8 + 2), 16'h0001);
				for (int i = 0; i < 8; i++) d = {d[6:0], bits_q[p + i]};
				chk(16'(d), 16'(n));
				chk(16'(first_one(p + 8) - p - 8), 16'h0058);
			end
		end
		end_sim();
	end
endmodule : tb_track_gate_sequencer

bind track_gate_sequencer track_gate_sequencer_assertions u_track_gate_sequencer_assertions (.clk_sys, .rst, .addr,
	.wdata, .wr, .clk_link, .index_pulse, .run_or_sector_input, .read_mark_in, .write_data_end, .read_gate_out,
	.write_gate_out);
